// >>> logic/sst_pkg.sv
// Purpose: shared constants and types for the skip/sub/table/xor executor
// Assumes: 8-bit data path, 14-bit program words, 1-cycle memories
// Notes:
package sst_pkg;
  localparam int DAW = 7;
  localparam int PAW = 10;
  localparam int PDW = 14;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [PAW-1:0] PC_RST = 10'h000;
  localparam logic [1:0] LAST_PAGE = 2'h3;

  typedef enum logic [4:0] {
    OP_NOP, OP_DEC_SKIP_ACC, OP_INC_SKIP_MEM, OP_INC_SKIP_ACC, OP_SET_BYTE,
    OP_SET_BIT, OP_SKIP_BIT_ONE, OP_SKIP_BIT_ZERO, OP_SKIP_ZERO,
    OP_MOVE_ZERO_SKIP, OP_SUB_ACC, OP_SUB_MEM, OP_SUB_IMM, OP_SWAP_MEM,
    OP_SWAP_ACC, OP_TAB_PAGED, OP_TAB_CUR, OP_TAB_LAST, OP_XOR_ACC,
    OP_XOR_MEM, OP_XOR_IMM
  } sst_op_e;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_DUMMY = 3'b010,
    ST_TABLE = 3'b100
  } sst_state_e;

  typedef struct packed {
    sst_op_e        op;
    logic [DAW-1:0] addr;
    logic [2:0]     bit_sel;
    logic [7:0]     imm;
  } sst_instr_s;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } sst_flags_s;

  typedef struct packed {
    logic           we;
    logic [DAW-1:0] addr;
    logic [7:0]     wdata;
  } sst_dwrite_s;
endpackage

// >>> logic/sst_core.sv
// Purpose: executes skip, set, subtract, swap, table read and xor
// Assumes: instr_i valid each cycle instr_valid_i high; data memory read
//          combinationally by the caller at dmem_raddr_o; program memory
//          word read combinationally while prog_rd_o is high
// Notes: taken skips and table ops stall fetch one cycle via busy_o
module sst_core (
  input  wire logic                    clk_i,
  input  wire logic                    rstn_i,
  input  wire logic                    instr_valid_i,
  input  wire sst_pkg::sst_instr_s     instr_i,
  input  wire logic [7:0]              dmem_rdata_i,
  input  wire logic [sst_pkg::PDW-1:0] prog_rdata_i,
  input  wire logic [7:0]              tbl_ptr_low_i,
  input  wire logic [1:0]              tbl_ptr_high_i,
  input  wire logic [1:0]              cur_page_i,
  output logic [sst_pkg::DAW-1:0]      dmem_raddr_o,
  output sst_pkg::sst_dwrite_s         dmem_wr_o,
  output logic [sst_pkg::PAW-1:0]      prog_raddr_o,
  output logic                         prog_rd_o,
  output logic [7:0]                   acc_o,
  output sst_pkg::sst_flags_s          flags_o,
  output logic [7:0]                   table_high_byte_reg_o,
  output logic                         skip_o,
  output logic                         busy_o
);
  typedef struct packed {
    sst_pkg::sst_state_e  st;
    logic [7:0]           acc;
    sst_pkg::sst_flags_s  fl;
    logic [7:0]           table_high_byte_reg;
    sst_pkg::sst_dwrite_s wr;
    logic [sst_pkg::DAW-1:0] tab_dst;
    logic [sst_pkg::PAW-1:0] paddr;
    logic                 prd;
    logic                 skip;
    logic                 busy;
  } sst_state_s;

  sst_state_s s_r, s_nxt;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] b, m, sub_res, bit_mask;
  logic       ov;
  logic       take;

  assign m = dmem_rdata_i;
  assign dmem_raddr_o = instr_i.addr;
  assign bit_mask = BYTE_ONE_SHIFT(instr_i.bit_sel);
  assign take = (s_r.st == sst_pkg::ST_EXEC) && instr_valid_i;

  function automatic logic [7:0] BYTE_ONE_SHIFT(input logic [2:0] n);
    BYTE_ONE_SHIFT = sst_pkg::BYTE_ONE << n;
  endfunction

  // one subtractor serves all three subtract forms
  always_comb
  begin
    b = (instr_i.op == sst_pkg::OP_SUB_IMM) ? instr_i.imm : m;
    diff = {1'b0, s_r.acc} - {1'b0, b};
    ndiff = {1'b0, s_r.acc[3:0]} - {1'b0, b[3:0]};
    sub_res = diff[7:0];
    ov = (s_r.acc[7] ^ b[7]) & (s_r.acc[7] ^ sub_res[7]);
  end

  always_comb
  begin
    logic       sk;
    logic [7:0] r;
    sk = 1'b0;
    r = 8'h00;
    s_nxt = s_r;
    s_nxt.wr.we = 1'b0;
    s_nxt.prd = 1'b0;
    s_nxt.skip = 1'b0;
    s_nxt.busy = 1'b0;
    case (s_r.st)
      sst_pkg::ST_EXEC:
      begin
        if (instr_valid_i)
        begin
          s_nxt.wr.addr = instr_i.addr;
          case (instr_i.op)
            sst_pkg::OP_DEC_SKIP_ACC:
            begin
              r = m - sst_pkg::BYTE_ONE;
              s_nxt.acc = r;
              sk = (r == 8'h00);
            end
            sst_pkg::OP_INC_SKIP_MEM:
            begin
              r = m + sst_pkg::BYTE_ONE;
              s_nxt.wr.we = 1'b1;
              s_nxt.wr.wdata = r;
              sk = (r == 8'h00);
            end
            sst_pkg::OP_INC_SKIP_ACC:
            begin
              r = m + sst_pkg::BYTE_ONE;
              s_nxt.acc = r;
              sk = (r == 8'h00);
            end
            sst_pkg::OP_SET_BYTE:
            begin
              s_nxt.wr.we = 1'b1;
              s_nxt.wr.wdata = sst_pkg::BYTE_ONES;
            end
            sst_pkg::OP_SET_BIT:
            begin
              s_nxt.wr.we = 1'b1;
              s_nxt.wr.wdata = m | bit_mask;
            end
            sst_pkg::OP_SKIP_BIT_ONE:
              sk = |(m & bit_mask);
            sst_pkg::OP_SKIP_BIT_ZERO:
              sk = ~|(m & bit_mask);
            sst_pkg::OP_SKIP_ZERO:
              sk = (m == 8'h00);
            sst_pkg::OP_MOVE_ZERO_SKIP:
            begin
              s_nxt.acc = m;
              sk = (m == 8'h00);
            end
            sst_pkg::OP_SUB_ACC, sst_pkg::OP_SUB_MEM, sst_pkg::OP_SUB_IMM:
            begin
              if (instr_i.op == sst_pkg::OP_SUB_MEM)
              begin
                s_nxt.wr.we = 1'b1;
                s_nxt.wr.wdata = sub_res;
              end
              else
              begin
                s_nxt.acc = sub_res;
              end
              s_nxt.fl.ov = ov;
              s_nxt.fl.z = (sub_res == 8'h00);
              s_nxt.fl.ac = ~ndiff[4];
              s_nxt.fl.c = ~diff[8];
            end
            sst_pkg::OP_SWAP_MEM:
            begin
              s_nxt.wr.we = 1'b1;
              s_nxt.wr.wdata = {m[3:0], m[7:4]};
            end
            sst_pkg::OP_SWAP_ACC:
              s_nxt.acc = {m[3:0], m[7:4]};
            sst_pkg::OP_TAB_PAGED, sst_pkg::OP_TAB_CUR, sst_pkg::OP_TAB_LAST:
            begin
              s_nxt.prd = 1'b1;
              s_nxt.busy = 1'b1;
              s_nxt.tab_dst = instr_i.addr;
              s_nxt.st = sst_pkg::ST_TABLE;
              if (instr_i.op == sst_pkg::OP_TAB_PAGED)
                s_nxt.paddr = {tbl_ptr_high_i, tbl_ptr_low_i};
              else if (instr_i.op == sst_pkg::OP_TAB_CUR)
                s_nxt.paddr = {cur_page_i, tbl_ptr_low_i};
              else
                s_nxt.paddr = {sst_pkg::LAST_PAGE, tbl_ptr_low_i};
            end
            sst_pkg::OP_XOR_ACC:
            begin
              r = s_r.acc ^ m;
              s_nxt.acc = r;
              s_nxt.fl.z = (r == 8'h00);
            end
            sst_pkg::OP_XOR_MEM:
            begin
              r = s_r.acc ^ m;
              s_nxt.wr.we = 1'b1;
              s_nxt.wr.wdata = r;
              s_nxt.fl.z = (r == 8'h00);
            end
            sst_pkg::OP_XOR_IMM:
            begin
              r = s_r.acc ^ instr_i.imm;
              s_nxt.acc = r;
              s_nxt.fl.z = (r == 8'h00);
            end
            default:
              r = 8'h00;
          endcase
          // taken skip holds fetch one cycle for the dummy slot
          if (sk)
          begin
            s_nxt.skip = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.st = sst_pkg::ST_DUMMY;
          end
        end
      end
      sst_pkg::ST_DUMMY:
      begin
        // the instruction presented now is the cancelled one
        s_nxt.st = sst_pkg::ST_EXEC;
      end
      sst_pkg::ST_TABLE:
      begin
        s_nxt.wr.we = 1'b1;
        s_nxt.wr.addr = s_r.tab_dst;
        s_nxt.wr.wdata = prog_rdata_i[7:0];
        s_nxt.table_high_byte_reg = {2'h0, prog_rdata_i[sst_pkg::PDW-1:8]};
        s_nxt.st = sst_pkg::ST_EXEC;
      end
      default:
        s_nxt.st = sst_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_r <= '0;
      s_r.st <= sst_pkg::ST_EXEC;
      s_r.acc <= sst_pkg::ACC_RST;
      s_r.paddr <= sst_pkg::PC_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign dmem_wr_o = s_r.wr;
  assign prog_raddr_o = s_r.paddr;
  assign prog_rd_o = s_r.prd;
  assign acc_o = s_r.acc;
  assign flags_o = s_r.fl;
  assign table_high_byte_reg_o = s_r.table_high_byte_reg;
  assign skip_o = s_r.skip;
  assign busy_o = s_r.busy;

  // operands of the taken op are looked at one cycle back through $past
  a_dummy_no_state: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == sst_pkg::ST_DUMMY |=> !s_r.wr.we && $stable(s_r.acc)
      && $stable(s_r.fl)) else $error("cancelled slot changed state");
  a_skip_two_cyc: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    skip_o |-> s_r.st == sst_pkg::ST_DUMMY ##1 s_r.st == sst_pkg::ST_EXEC)
    else $error("skip not two cycles");
  a_skip_flags_kept: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    skip_o |-> $stable(flags_o)) else $error("skip changed flags");
  a_set_byte_ones: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == sst_pkg::ST_EXEC && instr_valid_i
      && instr_i.op == sst_pkg::OP_SET_BYTE
      |=> dmem_wr_o.we && dmem_wr_o.wdata == 8'hff)
    else $error("byte set wrong");
  a_sub_carry: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == sst_pkg::ST_EXEC && instr_valid_i
      && instr_i.op == sst_pkg::OP_SUB_ACC
      |=> flags_o.c == ($past(s_r.acc) >= $past(m)))
    else $error("borrow flag wrong");
  a_xor_acc_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == sst_pkg::ST_EXEC && instr_valid_i
      && instr_i.op == sst_pkg::OP_XOR_ACC
      |=> acc_o == ($past(s_r.acc) ^ $past(m)) && $stable(flags_o.c))
    else $error("xor result wrong");
  a_inc_mem_skip: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == sst_pkg::ST_EXEC && instr_valid_i
      && instr_i.op == sst_pkg::OP_INC_SKIP_MEM
      |=> skip_o == (dmem_wr_o.wdata == 8'h00))
    else $error("increment skip wrong");
  a_last_page_addr: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == sst_pkg::ST_EXEC && instr_valid_i
      && instr_i.op == sst_pkg::OP_TAB_LAST
      |=> prog_rd_o && prog_raddr_o[9:8] == 2'h3 ##1 dmem_wr_o.we)
    else $error("last page read wrong");
  a_dec_acc_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_DEC_SKIP_ACC
      |=> acc_o == $past(m) - 8'h01 && !dmem_wr_o.we
        && skip_o == (acc_o == 8'h00) && $stable(flags_o))
    else $error("decrement to acc wrong");
  a_inc_mem_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_INC_SKIP_MEM
      |=> dmem_wr_o.we && dmem_wr_o.wdata == $past(m) + 8'h01
        && $stable(acc_o) && $stable(flags_o))
    else $error("increment in memory wrong");
  a_inc_acc_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_INC_SKIP_ACC
      |=> acc_o == $past(m) + 8'h01 && !dmem_wr_o.we
        && skip_o == (acc_o == 8'h00) && $stable(flags_o))
    else $error("increment to acc wrong");
  a_skip_busy: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    skip_o |-> busy_o) else $error("skip without dummy slot");
  a_set_bit_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_SET_BIT
      |=> dmem_wr_o.we && $stable(flags_o) && dmem_wr_o.wdata
        == ($past(m) | (sst_pkg::BYTE_ONE << $past(instr_i.bit_sel))))
    else $error("bit set wrong");
  a_bit_one_skip: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_SKIP_BIT_ONE
      |=> skip_o == $past(m[instr_i.bit_sel]) && $stable(flags_o))
    else $error("skip on bit one wrong");
  a_bit_zero_skip: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_SKIP_BIT_ZERO
      |=> skip_o != $past(m[instr_i.bit_sel]) && $stable(flags_o))
    else $error("skip on bit zero wrong");
  a_zero_skip_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_SKIP_ZERO
      |=> skip_o == ($past(m) == 8'h00) && !dmem_wr_o.we
        && $stable(acc_o))
    else $error("skip on zero wrong");
  a_move_zero_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_MOVE_ZERO_SKIP
      |=> acc_o == $past(m) && skip_o == (acc_o == 8'h00)
        && $stable(flags_o))
    else $error("move zero skip wrong");
  a_sub_acc_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_SUB_ACC
      |=> acc_o == $past(s_r.acc) - $past(m)
        && flags_o.z == (acc_o == 8'h00))
    else $error("subtract to acc wrong");
  a_sub_mem_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_SUB_MEM
      |=> dmem_wr_o.we && dmem_wr_o.wdata == $past(s_r.acc) - $past(m)
        && $stable(acc_o))
    else $error("subtract to memory wrong");
  a_sub_imm_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_SUB_IMM
      |=> acc_o == $past(s_r.acc) - $past(instr_i.imm)
        && flags_o.c == ($past(s_r.acc) >= $past(instr_i.imm)))
    else $error("subtract immediate wrong");
  a_swap_mem_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_SWAP_MEM
      |=> dmem_wr_o.we && $stable(flags_o)
        && dmem_wr_o.wdata == {$past(m[3:0]), $past(m[7:4])})
    else $error("swap in memory wrong");
  a_swap_acc_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_SWAP_ACC
      |=> acc_o == {$past(m[3:0]), $past(m[7:4])} && !dmem_wr_o.we
        && $stable(flags_o))
    else $error("swap to acc wrong");
  a_paged_addr: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_TAB_PAGED
      |=> prog_rd_o && busy_o
        && prog_raddr_o == {$past(tbl_ptr_high_i), $past(tbl_ptr_low_i)})
    else $error("paged table address wrong");
  a_cur_page_addr: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_TAB_CUR
      |=> prog_rd_o
        && prog_raddr_o == {$past(cur_page_i), $past(tbl_ptr_low_i)})
    else $error("current page address wrong");
  a_table_write: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_r.st == sst_pkg::ST_TABLE
      |=> dmem_wr_o.we && dmem_wr_o.addr == $past(s_r.tab_dst)
        && dmem_wr_o.wdata == $past(prog_rdata_i[7:0]) && $stable(flags_o)
        && table_high_byte_reg_o
          == {2'h0, $past(prog_rdata_i[sst_pkg::PDW-1:8])})
    else $error("table word split wrong");
  a_xor_mem_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_XOR_MEM
      |=> dmem_wr_o.we && dmem_wr_o.wdata == ($past(s_r.acc) ^ $past(m))
        && flags_o.z == (dmem_wr_o.wdata == 8'h00)
        && $stable(acc_o) && $stable(flags_o.c))
    else $error("xor to memory wrong");
  a_xor_imm_val: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && instr_i.op == sst_pkg::OP_XOR_IMM
      |=> acc_o == ($past(s_r.acc) ^ $past(instr_i.imm))
        && flags_o.z == (acc_o == 8'h00) && $stable(flags_o.ov))
    else $error("xor immediate wrong");
endmodule

// >>> tb/sst_core_test.sv
// Purpose: self-checking bench for the skip/sub/table/xor executor
// Assumes: bench drives every input, data memory byte given per instruction
// Notes: a skipped slot carries a byte-set that must never land
module sst_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      clk_i         = 1'b0;
  logic                      rstn_i        = 1'b0;
  logic                      instr_valid_i = 1'b0;
  sst_pkg::sst_instr_s       instr_i       = '0;
  logic [7:0]                dmem_rdata_i  = 8'h00;
  logic [sst_pkg::PDW-1:0]   prog_rdata_i  = '0;
  logic [7:0]                tlo           = 8'h00;
  logic [1:0]                thi           = 2'h0;
  logic [1:0]                cpg           = 2'h0;
  logic [sst_pkg::DAW-1:0]   dmem_raddr_o;
  sst_pkg::sst_dwrite_s      dmem_wr_o;
  logic [sst_pkg::PAW-1:0]   prog_raddr_o;
  logic                      prog_rd_o;
  logic [7:0]                acc_o;
  sst_pkg::sst_flags_s       flags_o;
  logic [7:0]                table_high_byte_reg;
  logic                      skip_o;
  logic                      busy_o;
  int                        fails         = 0;
  int                        num_checks    = 0;
  logic [7:0]                ea            = 8'h00;
  logic [3:0]                ef            = 4'h0;

  sst_core DUT (
    .clk_i                 (clk_i),
    .rstn_i                (rstn_i),
    .instr_valid_i         (instr_valid_i),
    .instr_i               (instr_i),
    .dmem_rdata_i          (dmem_rdata_i),
    .prog_rdata_i          (prog_rdata_i),
    .tbl_ptr_low_i         (tlo),
    .tbl_ptr_high_i        (thi),
    .cur_page_i            (cpg),
    .dmem_raddr_o          (dmem_raddr_o),
    .dmem_wr_o             (dmem_wr_o),
    .prog_raddr_o          (prog_raddr_o),
    .prog_rd_o             (prog_rd_o),
    .acc_o                 (acc_o),
    .flags_o               (flags_o),
    .table_high_byte_reg_o (table_high_byte_reg),
    .skip_o                (skip_o),
    .busy_o                (busy_o)
  );

  always #20 clk_i = ~clk_i;

  // expected {ov,z,ac,c} of a - b, carry meaning no borrow
  function automatic logic [3:0] subf(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = a - b;
    return {(a[7] != b[7]) && (r[7] != a[7]), r == 8'h00,
            a[3:0] >= b[3:0], a >= b};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // x carries both bit select and immediate; w is {we, wdata}
  task automatic op(input sst_pkg::sst_op_e o, input logic [7:0] x,
                    input logic [7:0] md, input logic [8:0] w,
                    input logic sk);
    @(posedge clk_i);
    instr_i <= '{o, 7'h2a, x[2:0], x};
    dmem_rdata_i <= md;
    instr_valid_i <= 1'b1;
    #1;
    check("raddr", dmem_raddr_o, 7'h2a);
    @(posedge clk_i);
    // a byte-set in the dummy slot exposes a skip that was not honoured
    instr_valid_i <= sk;
    instr_i <= '{sst_pkg::OP_SET_BYTE, 7'h2a, 3'h0, 8'h00};
    dmem_rdata_i <= ~md;
    #1;
    check("acc", acc_o, ea);
    check("flags", flags_o, ef);
    check("we", dmem_wr_o.we, w[8]);
    if (w[8])
    begin
      check("wdata", dmem_wr_o.wdata, w[7:0]);
      check("waddr", dmem_wr_o.addr, 7'h2a);
    end
    check("skip", skip_o, sk);
    check("busy", busy_o, sk);
    if (sk)
    begin
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      check("dummy we", dmem_wr_o.we, 1'b0);
      check("dummy acc", acc_o, ea);
    end
  endtask

  task automatic tab(input sst_pkg::sst_op_e o,
                     input logic [13:0] wd, input logic [9:0] pa);
    @(posedge clk_i);
    instr_i <= '{o, 7'h2a, 3'h0, 8'h00};
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    // word is taken in the fetch cycle; a byte-set there must be dropped
    instr_i <= '{sst_pkg::OP_SET_BYTE, 7'h15, 3'h0, 8'h00};
    prog_rdata_i <= wd;
    #1;
    check("prog rd", prog_rd_o, 1'b1);
    check("prog addr", prog_raddr_o, pa);
    check("tab busy", busy_o, 1'b1);
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    prog_rdata_i <= ~wd;
    #1;
    check("tab we", dmem_wr_o.we, 1'b1);
    check("tab addr", dmem_wr_o.addr, 7'h2a);
    check("tab low", dmem_wr_o.wdata, wd[7:0]);
    check("tab high", table_high_byte_reg, {2'h0, wd[13:8]});
    check("tab flags", flags_o, ef);
    check("tab end", {prog_rd_o, busy_o}, 2'h0);
  endtask

  task automatic t_reset();
    check("rst acc", acc_o, 8'h00);
    check("rst flags", flags_o, 4'h0);
    check("rst busy", {skip_o, busy_o, prog_rd_o, dmem_wr_o.we}, 4'h0);
    $display("test reset done");
  endtask

  task automatic t_sub();
    ea = 8'h3c;
    op(sst_pkg::OP_XOR_IMM, 8'h3c, 8'h00, 9'h000, 1'b0);
    ea = 8'hef;
    ef = subf(8'h3c, 8'h4d);
    op(sst_pkg::OP_SUB_ACC, 8'h00, 8'h4d, 9'h000, 1'b0);
    ea = 8'h6f;
    ef = subf(8'hef, 8'h80);
    op(sst_pkg::OP_SUB_IMM, 8'h80, 8'h00, 9'h000, 1'b0);
    ef = subf(8'h6f, 8'hef);
    op(sst_pkg::OP_SUB_MEM, 8'h00, 8'hef, 9'h180, 1'b0);
    ea = 8'h00;
    ef = subf(8'h6f, 8'h6f);
    op(sst_pkg::OP_SUB_IMM, 8'h6f, 8'h00, 9'h000, 1'b0);
    $display("test sub done");
  endtask

  task automatic t_xor();
    ea = 8'h5a;
    ef[2] = 1'b0;
    op(sst_pkg::OP_XOR_ACC, 8'h00, 8'h5a, 9'h000, 1'b0);
    ef[2] = 1'b1;
    op(sst_pkg::OP_XOR_MEM, 8'h00, 8'h5a, 9'h100, 1'b0);
    ea = 8'h00;
    op(sst_pkg::OP_XOR_IMM, 8'h5a, 8'h00, 9'h000, 1'b0);
    $display("test xor done");
  endtask

  task automatic t_skip();
    op(sst_pkg::OP_DEC_SKIP_ACC, 8'h00, 8'h01, 9'h000, 1'b1);
    ea = 8'hff;
    op(sst_pkg::OP_DEC_SKIP_ACC, 8'h00, 8'h00, 9'h000, 1'b0);
    op(sst_pkg::OP_INC_SKIP_MEM, 8'h00, 8'hff, 9'h100, 1'b1);
    op(sst_pkg::OP_INC_SKIP_MEM, 8'h00, 8'h7f, 9'h180, 1'b0);
    ea = 8'h00;
    op(sst_pkg::OP_INC_SKIP_ACC, 8'h00, 8'hff, 9'h000, 1'b1);
    ea = 8'h80;
    op(sst_pkg::OP_INC_SKIP_ACC, 8'h00, 8'h7f, 9'h000, 1'b0);
    op(sst_pkg::OP_SKIP_BIT_ONE, 8'h07, 8'h80, 9'h000, 1'b1);
    op(sst_pkg::OP_SKIP_BIT_ONE, 8'h00, 8'hfe, 9'h000, 1'b0);
    op(sst_pkg::OP_SKIP_BIT_ZERO, 8'h03, 8'hf7, 9'h000, 1'b1);
    op(sst_pkg::OP_SKIP_BIT_ZERO, 8'h03, 8'h08, 9'h000, 1'b0);
    op(sst_pkg::OP_SKIP_ZERO, 8'h00, 8'h00, 9'h000, 1'b1);
    op(sst_pkg::OP_SKIP_ZERO, 8'h00, 8'h01, 9'h000, 1'b0);
    ea = 8'h00;
    op(sst_pkg::OP_MOVE_ZERO_SKIP, 8'h00, 8'h00, 9'h000, 1'b1);
    ea = 8'h5a;
    op(sst_pkg::OP_MOVE_ZERO_SKIP, 8'h00, 8'h5a, 9'h000, 1'b0);
    $display("test skip done");
  endtask

  task automatic t_set();
    op(sst_pkg::OP_SET_BYTE, 8'h00, 8'h12, 9'h1ff, 1'b0);
    op(sst_pkg::OP_SET_BIT, 8'h05, 8'h00, 9'h120, 1'b0);
    op(sst_pkg::OP_SET_BIT, 8'h07, 8'h41, 9'h1c1, 1'b0);
    op(sst_pkg::OP_SWAP_MEM, 8'h00, 8'ha5, 9'h15a, 1'b0);
    ea = 8'h3c;
    op(sst_pkg::OP_SWAP_ACC, 8'h00, 8'hc3, 9'h000, 1'b0);
    $display("test set swap done");
  endtask

  task automatic t_table();
    tlo <= 8'h9e;
    thi <= 2'h1;
    cpg <= 2'h2;
    tab(sst_pkg::OP_TAB_PAGED, 14'h2b7c, 10'h19e);
    tab(sst_pkg::OP_TAB_CUR, 14'h3fc1, 10'h29e);
    tab(sst_pkg::OP_TAB_LAST, 14'h0155, 10'h39e);
    $display("test table done");
  endtask

  initial
  begin
    #(4000 * 40);
    fails++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    t_reset();
    t_sub();
    t_xor();
    t_skip();
    t_set();
    t_table();
    conclude();
  end
endmodule
